// ---- logic/display_port_params.svh ----
// Purpose: Constants of the host command port: register indices, fields, command codes.
// Assumes: Included by the port module after the package is compiled.
// Notes:   Definitions only.
`ifndef DISPLAY_PORT_PARAMS_SVH
`define DISPLAY_PORT_PARAMS_SVH

// Direct register indices.
`define IX_CMD      3'h0
`define IX_DATA1    3'h1
`define IX_DATA3    3'h3
`define IX_AP_HI    3'h4
`define IX_AP_LO    3'h5
`define IX_MP_HI    3'h6
`define IX_MP_LO    3'h7

// Address decode.
`define ASN_SELECT  4'h2

// Command type field, upper nibble of the command register.
`define CT_TLM      4'h0
`define CT_TLA      4'h2
`define CT_TB       4'h3
`define CT_KRS      4'h4
`define CT_KRL      4'h5
`define CT_TSM      4'h6
`define CT_TSA      4'h7
`define CT_INY      4'hb
`define CT_MVB      4'hd
`define CT_MVD      4'he
`define CT_MVT      4'hf

// Whole command codes.
`define CMD_NOP     8'h91
`define CMD_MASK_SET 8'h99
`define CMD_MASK_CLR 8'h95

// Parameter bit positions.
`define PB_DIR      3
`define PB_PSEL     2
`define PB_INC      0

// Buffer move encodings.
`define MV_AP_TO_MP 2'h2
`define MV_STOP_END 2'h1

// Status bit positions.
`define ST_BUSY     7
`define ST_ALARM    6
`define ST_LXM      5
`define ST_LXA      4
`define ST_SYNC     2

// Row geometry.
`define COL_LAST    6'h27
`define BUF_LEN     15'h0028

// Reset values.
`define MASK_RST    1'b1

`endif

// ---- logic/display_port_pkg.sv ----
// Purpose: Types shared by the host command port and its bench.
// Assumes: Nothing.
// Notes:   Constants live in the params header.
package display_port_pkg;

    typedef struct packed {
        logic       latched_select;
        logic [3:0] auto_select_nibble;
        logic       execute_request_bit;
        logic [2:0] index;
    } host_addr_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [14:0] addr;
        logic [7:0]  wdata;
    } mem_req_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_NEXT,
        ST_MEM
    } eng_state_t;

endpackage

// ---- logic/display_host_command_port.sv ----
// Purpose: Host side command port: address latch, direct registers, status, command engine.
// Assumes: All host pins and the sync input are asynchronous to mclk_i.
// Notes:   Memory is reached through a request/acknowledge port on mclk_i.
`timescale 1ns/1ps
`include "display_port_params.svh"

// Operation
// - Address strobe fall captures the eight bus lines and chip select.
// - Captured word splits into index, execute bit, select nibble, latched select.
// - Respond only when select nibble is 2 and latched select is low.
// - Unselected device floats its bus and changes no register.
// - Index 0 is command write and status read; 1 to 7 are arguments.
// - Command register: type in upper nibble, four parameters in lower nibble.
// - Direction 1 loads data registers, 0 takes data from them.
// - Increment bit requests post increment; pointer bit chooses auxiliary pointer in byte transfers.
// - Move source code 01 is main to auxiliary, 10 auxiliary to main.
// - Move stop code 01 stops at buffer end, 10 never stops.
// - Busy bit sets when a command starts and clears at completion.
// - Row end flag sets when that pointer holds column 39 before incrementing.
// - Alarm sets when a row end flag sets and an increment follows.
// - Status bit 2 shows the sync input, or zero while masked.
// - Bits 3, 1, 0 read zero; bits 3 to 6 clear at command start.
// - Execution starts at strobe trailing edge when selected with execute bit.
// - Arguments and command load in any order; commands may be relaunched.
// - Busy without execute bit: only status reads act, others are ignored.
// - Busy with execute bit: a command write aborts and launches the new command.
// - Long code transfer moves data regs 1 and 3, merging the attribute nibble.
// - Long code pairs sit in three buffers: even, odd, both nibbles.
// - Mask set forces status bit 2 low; mask clear lets it follow sync.
module display_host_command_port (
    input  wire logic                  mclk_i,
    input  wire logic                  rst_b_i,
    input  wire logic [7:0]            ad_i,
    output logic [7:0]                 ad_o,
    output logic                       ad_oe_o,
    input  wire logic                  address_strobe_i,
    input  wire logic                  data_strobe_i,
    input  wire logic                  rw_i,
    input  wire logic                  cs_b_i,
    input  wire logic                  sync_in_i,
    output display_port_pkg::mem_req_t mem_req_o,
    input  wire logic [7:0]            mem_rdata_i,
    input  wire logic                  mem_ack_i
);
    import display_port_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////

    function automatic logic [15:0] bump(input logic [15:0] ptr, input logic y_ovf);
        logic [15:0] res;
        res = ptr;
        if (ptr[5:0] == `COL_LAST) begin
            res[5:0]  = 6'h00;
            res[15:8] = ptr[15:8] + {7'h00, y_ovf};
        end else begin
            res[5:0] = ptr[5:0] + 6'h01;
        end
        return res;
    endfunction

    // Buffers of one row are 40 bytes apart.
    function automatic logic [14:0] code_addr(input logic [7:0] hi, input logic [7:0] lo,
                                              input logic [1:0] buf_sel);
        logic [14:0] base;
        base = {hi[6:0], 8'h00};
        return base + (`BUF_LEN * {13'h0000, buf_sel}) + {9'h000, lo[5:0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    logic [12:0] pin_s1_q;
    logic [12:0] pin_s2_q;
    logic [7:0]  ad_s;
    logic        as_s;
    logic        ds_s;
    logic        rw_s;
    logic        cs_b_s;
    logic        sync_s;

    always_ff @(posedge mclk_i) begin
        pin_s1_q <= {sync_in_i, cs_b_i, rw_i, data_strobe_i, address_strobe_i, ad_i};
        pin_s2_q <= pin_s1_q;
    end

    assign {sync_s, cs_b_s, rw_s, ds_s, as_s, ad_s} = pin_s2_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Address phase and data phase decode.

    host_addr_t  addr_q;
    logic        ds_mode_q;
    logic        as_prev_q;
    logic        act_prev_q;
    logic        wr_prev_q;
    logic [7:0]  wdata_hold_q;
    logic        busy_q;

    wire         as_fall  = as_prev_q & ~as_s;
    wire         selected = (addr_q.auto_select_nibble == `ASN_SELECT)
                          & ~addr_q.latched_select;
    wire         is_r0    = (addr_q.index == `IX_CMD);
    // Data strobe high at the address edge selects the separate read/write strobe style.
    wire         rd_act   = selected & ~as_s & (ds_mode_q ? ~ds_s : (ds_s & rw_s));
    wire         wr_act   = selected & ~as_s & (ds_mode_q ? ~rw_s : (ds_s & ~rw_s));
    wire         act      = rd_act | wr_act;
    wire         acc_end  = act_prev_q & ~act;
    wire         wr_end   = acc_end & wr_prev_q;
    wire         wr_ok    = ~busy_q | (addr_q.execute_request_bit & is_r0);
    wire         commit   = wr_end & wr_ok;
    wire         launch   = acc_end & addr_q.execute_request_bit
                          & (~busy_q | (is_r0 & wr_prev_q));

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            addr_q       <= '0;
            ds_mode_q    <= 1'b0;
            as_prev_q    <= 1'b1;
            act_prev_q   <= 1'b0;
            wr_prev_q    <= 1'b0;
            wdata_hold_q <= 8'h00;
        end else begin
            as_prev_q  <= as_s;
            act_prev_q <= act;
            wr_prev_q  <= wr_act;
            if (as_fall) begin
                addr_q    <= {cs_b_s, ad_s};
                ds_mode_q <= ds_s;
            end
            if (wr_act) begin
                wdata_hold_q <= ad_s;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Command decode.

    logic [7:0]  arg_q [0:7];
    logic [7:0]  attr_q;
    logic [1:0]  step_q;
    eng_state_t  state_q;
    mem_req_t    mem_req_q;

    wire [7:0]   cmd_q   = arg_q[`IX_CMD];
    wire [3:0]   ctype   = cmd_q[7:4];
    wire         is_tl   = (ctype == `CT_TLM) | (ctype == `CT_TLA);
    wire         is_ts   = (ctype == `CT_TSM) | (ctype == `CT_TSA);
    wire         is_krs  = (ctype == `CT_KRS);
    wire         is_krl  = (ctype == `CT_KRL);
    wire         is_tb   = (ctype == `CT_TB);
    wire         is_mv   = (ctype == `CT_MVB) | (ctype == `CT_MVD) | (ctype == `CT_MVT);
    wire         ptr_cmd = is_tl | is_ts | is_krs | is_krl | is_tb;
    wire         dir_rd  = cmd_q[`PB_DIR];
    wire         inc     = cmd_q[`PB_INC];
    wire         use_aux = (ctype == `CT_TLA) | (ctype == `CT_TSA)
                         | (is_tb & cmd_q[`PB_PSEL]);

    wire [7:0]   p_hi    = use_aux ? arg_q[`IX_AP_HI] : arg_q[`IX_MP_HI];
    wire [7:0]   p_lo    = use_aux ? arg_q[`IX_AP_LO] : arg_q[`IX_MP_LO];
    wire         col_last = (p_lo[5:0] == `COL_LAST);

    wire [1:0]   nsteps  = is_tl  ? 2'd3 :
                           is_ts  ? 2'd2 :
                           is_krl ? (dir_rd ? 2'd2 : 2'd3) :
                           (is_krs | is_tb) ? 2'd1 :
                           is_mv  ? 2'd2 : 2'd0;

    // Buffer moves.
    wire         mv_src_aux = (cmd_q[3:2] == `MV_AP_TO_MP);
    wire         mv_no_stop = (cmd_q[1:0] != `MV_STOP_END);
    wire [15:0]  mp_ptr  = {arg_q[`IX_MP_HI], arg_q[`IX_MP_LO]};
    wire [15:0]  ap_ptr  = {arg_q[`IX_AP_HI], arg_q[`IX_AP_LO]};
    wire [15:0]  src_ptr = mv_src_aux ? ap_ptr : mp_ptr;
    wire [15:0]  dst_ptr = mv_src_aux ? mp_ptr : ap_ptr;
    wire         mv_stop = ~mv_no_stop & ((src_ptr[5:0] == `COL_LAST)
                                        | (dst_ptr[5:0] == `COL_LAST));
    wire [15:0]  mp_mv_next = bump(mp_ptr, mv_no_stop);
    wire [15:0]  ap_mv_next = bump(ap_ptr, 1'b0);

    // Memory operation for the current step.
    wire [2:0]   dreg    = (is_tl | is_ts) ? (3'(step_q) + 3'h1) : `IX_DATA1;
    wire [7:0]   merged  = p_lo[7] ? {arg_q[`IX_DATA3][3:0], attr_q[3:0]}
                                   : {attr_q[7:4], arg_q[`IX_DATA3][3:0]};
    wire [14:0]  op_addr = is_mv ? ((step_q == 2'd0) ? src_ptr[14:0] : dst_ptr[14:0]) :
                           is_tb ? {p_hi[6:0], p_lo} :
                           (is_krl & (step_q != 2'd0)) ? code_addr(p_hi, p_lo, 2'd2) :
                           (is_krl | is_krs) ? code_addr(p_hi, p_lo, {1'b0, p_lo[7]}) :
                           code_addr(p_hi, p_lo, step_q);
    wire         op_we   = is_mv ? (step_q == 2'd1) :
                           (is_krl & (step_q == 2'd1)) ? 1'b0 : ~dir_rd;
    wire [7:0]   op_wdata = (is_krl & (step_q == 2'd2)) ? merged : arg_q[dreg];

    // Long codes step through the odd half before moving to the next pair.
    wire [15:0]  krl_next = p_lo[7] ? bump({p_hi, 1'b0, p_lo[6:0]}, 1'b0)
                                    : {p_hi, 1'b1, p_lo[6:0]};
    wire [15:0]  xfer_next = is_krl ? krl_next : bump({p_hi, p_lo}, is_tb & ~use_aux);

    wire         st_next   = (state_q == ST_NEXT);
    wire         st_mem    = (state_q == ST_MEM);
    wire         rd_ack    = st_mem & mem_ack_i & ~mem_req_q.we;
    wire         mv_iter   = st_next & is_mv & (step_q == 2'd2);
    wire         finish    = st_next & ((~is_mv & (step_q == nsteps)) | (mv_iter & mv_stop));

    ////////////////////////////////////////////////////////////////////////////////
    // Direct registers.

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < 8; i++) begin
                arg_q[i] <= 8'h00;
            end
        end else begin
            if (commit) begin
                arg_q[addr_q.index] <= wdata_hold_q;
            end
            if (rd_ack) begin
                if (is_krl & (step_q == 2'd1)) begin
                    arg_q[`IX_DATA3] <= p_lo[7] ? {2{mem_rdata_i[7:4]}}
                                                : {2{mem_rdata_i[3:0]}};
                end else begin
                    arg_q[dreg] <= mem_rdata_i;
                end
            end
            if (finish & ptr_cmd & inc) begin
                if (use_aux) begin
                    {arg_q[`IX_AP_HI], arg_q[`IX_AP_LO]} <= xfer_next;
                end else begin
                    {arg_q[`IX_MP_HI], arg_q[`IX_MP_LO]} <= xfer_next;
                end
            end
            if (finish & (ctype == `CT_INY)) begin
                arg_q[`IX_MP_HI] <= arg_q[`IX_MP_HI] + 8'h01;
            end
            if (mv_iter) begin
                {arg_q[`IX_MP_HI], arg_q[`IX_MP_LO]} <= mp_mv_next;
                {arg_q[`IX_AP_HI], arg_q[`IX_AP_LO]} <= ap_mv_next;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Command engine. A new launch simply restarts it, which is how an abort works.

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            state_q   <= ST_IDLE;
            step_q    <= 2'd0;
            mem_req_q <= '0;
            attr_q    <= 8'h00;
        end else if (launch) begin
            state_q       <= ST_NEXT;
            step_q        <= 2'd0;
            mem_req_q.req <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    step_q <= 2'd0;
                end
                ST_NEXT: begin
                    if (mv_iter) begin
                        step_q  <= 2'd0;
                        state_q <= mv_stop ? ST_IDLE : ST_NEXT;
                    end else if (step_q < nsteps) begin
                        mem_req_q <= '{req: 1'b1, we: op_we, addr: op_addr, wdata: op_wdata};
                        state_q   <= ST_MEM;
                    end else begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_MEM: begin
                    if (mem_ack_i) begin
                        mem_req_q.req <= 1'b0;
                        step_q        <= step_q + 2'd1;
                        state_q       <= ST_NEXT;
                        if (is_krl & (step_q == 2'd1)) begin
                            attr_q <= mem_rdata_i;
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Status flags.

    logic alarm_q;
    logic lxm_q;
    logic lxa_q;
    logic mask_q;

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            busy_q  <= 1'b0;
            alarm_q <= 1'b0;
            lxm_q   <= 1'b0;
            lxa_q   <= 1'b0;
            mask_q  <= `MASK_RST;
        end else if (launch) begin
            busy_q  <= 1'b1;
            alarm_q <= 1'b0;
            lxm_q   <= 1'b0;
            lxa_q   <= 1'b0;
        end else if (finish) begin
            busy_q <= 1'b0;
            if (ptr_cmd) begin
                lxm_q   <= ~use_aux & col_last;
                lxa_q   <= use_aux & col_last;
                alarm_q <= col_last & inc;
            end
            if (cmd_q == `CMD_MASK_SET) begin
                mask_q <= 1'b1;
            end
            if (cmd_q == `CMD_MASK_CLR) begin
                mask_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read path. Outputs are registered, so read data trails the strobe by a cycle.

    wire       sync_bit = ~mask_q & sync_s;
    wire [7:0] status   = {busy_q, alarm_q, lxm_q, lxa_q, 1'b0, sync_bit, 2'b00};
    // Argument reads while busy are not defined; zero is returned.
    wire [7:0] rd_data  = is_r0 ? status : (busy_q ? 8'h00 : arg_q[addr_q.index]);

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            ad_o    <= 8'h00;
            ad_oe_o <= 1'b0;
        end else begin
            ad_o    <= rd_data;
            ad_oe_o <= rd_act;
        end
    end

    assign mem_req_o = mem_req_q;

endmodule

// ---- verification/display_mem_model.sv ----
// Purpose: Memory behind the command port, answering held requests after a set delay.
// Assumes: Requests follow the request/acknowledge contract of the port.
// Notes:   Read data is scrambled outside the ack cycle so a late sample is caught.
`timescale 1ns/1ps
module display_mem_model (
    input  wire logic                       mclk_i,
    input  wire logic                       rst_b_i,
    input  wire display_port_pkg::mem_req_t mem_req_i,
    input  wire logic [7:0]                 delay_i,
    output logic [7:0]                      mem_rdata_o,
    output logic                            mem_ack_o
);
    import display_port_pkg::*;
    logic [7:0] mem [0:32767];
    logic [7:0] cnt_q;
    // Plain always: the bench preloads the array directly, which always_ff would refuse.
    always @(posedge mclk_i) begin
        mem_ack_o <= 1'b0;
        mem_rdata_o <= ~mem_rdata_o;
        if (!rst_b_i) begin
            cnt_q <= 8'h00;
            mem_rdata_o <= 8'h00;
        end else if (mem_req_i.req && !mem_ack_o) begin
            if (cnt_q == delay_i) begin
                mem_ack_o <= 1'b1;
                cnt_q <= 8'h00;
                if (mem_req_i.we) begin
                    mem[mem_req_i.addr] <= mem_req_i.wdata;
                end else begin
                    mem_rdata_o <= mem[mem_req_i.addr];
                end
            end else begin
                cnt_q <= cnt_q + 8'h01;
            end
        end else begin
            cnt_q <= 8'h00;
        end
    end
endmodule

// ---- verification/display_port_asserts.sv ----
// Purpose: Port checks of the host command port.
// Assumes: Host uses the style with data strobe low at the address strobe fall.
// Notes:   The select latch here is two clocks ahead of the port's own latch.
`timescale 1ns/1ps
module display_port_asserts (
    input wire logic                       mclk_i,
    input wire logic                       rst_b_i,
    input wire logic [7:0]                 ad_i,
    input wire logic [7:0]                 ad_o,
    input wire logic                       ad_oe_o,
    input wire logic                       address_strobe_i,
    input wire logic                       data_strobe_i,
    input wire logic                       rw_i,
    input wire logic                       cs_b_i,
    input wire logic                       sync_in_i,
    input wire display_port_pkg::mem_req_t mem_req_o,
    input wire logic [7:0]                 mem_rdata_i,
    input wire logic                       mem_ack_i
);
    import display_port_pkg::*;
    logic as_q, ds_q, sel_q, xqr_q, launched_q;
    wire  as_fall = as_q & ~address_strobe_i;
    wire  ds_fall = ds_q & ~data_strobe_i;
    wire  sel_now = (ad_i[7:4] == 4'h2) & ~cs_b_i;
    always_ff @(posedge mclk_i) begin
        as_q <= address_strobe_i;
        ds_q <= data_strobe_i;
    end
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            sel_q <= 1'b0;
            xqr_q <= 1'b0;
            launched_q <= 1'b0;
        end else begin
            if (as_fall) begin
                sel_q <= sel_now;
                xqr_q <= ad_i[3];
            end
            if (ds_fall && sel_q && xqr_q) begin
                launched_q <= 1'b1;
            end
        end
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_read_start;
        $rose(data_strobe_i) && sel_q && rw_i && !address_strobe_i;
    endsequence
    sequence s_oe_up;
        ##[2:4] ad_oe_o ##1 ad_oe_o[*2];
    endsequence
    chk_read_drive: assert property (s_read_start |-> s_oe_up)
        else $error("Selected read did not drive the bus in time");
    chk_unsel_float: assert property ($rose(ad_oe_o) |-> sel_q)
        else $error("Bus driven without selection");
    chk_oe_latched: assert property (ad_oe_o |-> sel_q)
        else $error("Bus driven after the latched select was lost");
    chk_float_release: assert property ($fell(data_strobe_i) |-> ##[1:4] !ad_oe_o)
        else $error("Bus not released after the data phase");
    chk_drive_read: assert property (ad_oe_o |-> rw_i && !address_strobe_i)
        else $error("Bus driven outside a read phase");
    chk_req_launch: assert property ($rose(mem_req_o.req) |-> launched_q)
        else $error("Memory request without a launched command");
    chk_req_hold: assert property (mem_req_o.req && !mem_ack_i |=>
        !mem_req_o.req || $stable(mem_req_o))
        else $error("Memory request changed while waiting");
    chk_req_drop: assert property (mem_req_o.req && mem_ack_i |=> !mem_req_o.req)
        else $error("Memory request held after ack");
endmodule

bind display_host_command_port display_port_asserts i_display_port_asserts (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .ad_i(ad_i), .ad_o(ad_o), .ad_oe_o(ad_oe_o),
    .address_strobe_i(address_strobe_i), .data_strobe_i(data_strobe_i), .rw_i(rw_i),
    .cs_b_i(cs_b_i), .sync_in_i(sync_in_i), .mem_req_o(mem_req_o),
    .mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i));

// ---- verification/display_host_command_port_tb.sv ----
// Purpose: Self-checking bench of the host command port.
// Assumes: Host cycles with data strobe low at the address strobe fall.
// Notes:   Each bus cycle takes 22 clocks, well above the synchroniser delay.
`timescale 1ns/1ps
module display_host_command_port_tb;
    import display_port_pkg::*;
    logic       mclk_i, rst_b_i, as_i, ds_i, rw_i, cs_b_i, sync_i, oe_o, ack_i;
    logic [7:0] ad_i, ad_o, rdata_i, dly_i, st;
    mem_req_t   req_o;
    int         n_errors, compares, cycles;
    display_host_command_port i_display_host_command_port (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
        .ad_i(ad_i), .ad_o(ad_o), .ad_oe_o(oe_o), .address_strobe_i(as_i), .data_strobe_i(ds_i),
        .rw_i(rw_i), .cs_b_i(cs_b_i), .sync_in_i(sync_i), .mem_req_o(req_o),
        .mem_rdata_i(rdata_i), .mem_ack_i(ack_i));
    display_mem_model i_display_mem_model (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
        .mem_req_i(req_o), .delay_i(dly_i), .mem_rdata_o(rdata_i), .mem_ack_o(ack_i));
    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("Comparisons %0d, errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic c, input logic r, input logic [7:0] d,
                       output logic [7:0] q, output logic oe);
        ad_i <= a; cs_b_i <= c; rw_i <= r; as_i <= 1'b1; ds_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        as_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        ad_i <= r ? ~a : d; ds_i <= 1'b1;
        repeat (6) @(posedge mclk_i);
        q = ad_o; oe = oe_o;
        ds_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        as_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
    endtask
    task automatic wr(input logic [2:0] i, input logic x, input logic [7:0] d);
        logic [7:0] q;
        logic oe;
        bus({4'h2, x, i}, 1'b0, 1'b0, d, q, oe);
    endtask
    task automatic rd(input logic [2:0] i, input logic [7:0] exp);
        logic [7:0] q;
        logic oe;
        bus({4'h2, 1'b0, i}, 1'b0, 1'b1, 8'h00, q, oe);
        check(q, exp);
    endtask
    task automatic wait_idle(output logic [7:0] s);
        logic oe;
        for (int k = 0; k < 40; k++) begin
            bus(8'h20, 1'b0, 1'b1, 8'h00, s, oe);
            if (s[7] === 1'b0) return;
        end
        n_errors++;
        $display("Error at %0t: busy never cleared", $time);
    endtask
    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [7:0] q;
        logic oe;
        for (int i = 1; i < 8; i++) wr(3'(i), 1'b0, 8'h5a ^ 8'(i));
        for (int i = 1; i < 8; i++) rd(3'(i), 8'h5a ^ 8'(i));
        bus(8'h21, 1'b1, 1'b0, 8'hff, q, oe);
        bus(8'h31, 1'b0, 1'b0, 8'hff, q, oe);
        bus(8'h21, 1'b1, 1'b1, 8'h00, q, oe);
        check({7'h00, oe}, 8'h00);
        rd(3'h1, 8'h5b);
    endtask
    task automatic t_byte_read();
        i_display_mem_model.mem[15'h0105] = 8'ha5;
        wr(3'h6, 1'b0, 8'h01);
        wr(3'h7, 1'b0, 8'h05);
        wr(3'h0, 1'b1, 8'h39);
        wait_idle(st);
        check(st, 8'h00);
        rd(3'h1, 8'ha5);
        rd(3'h7, 8'h06);
        wr(3'h6, 1'b0, 8'h04);
        wr(3'h7, 1'b0, 8'h85);
        wr(3'h1, 1'b0, 8'h77);
        wr(3'h0, 1'b1, 8'h41);
        wait_idle(st);
        check(i_display_mem_model.mem[15'h042d], 8'h77);
        rd(3'h7, 8'h86);
    endtask
    task automatic t_row_end();
        wr(3'h6, 1'b0, 8'h02);
        wr(3'h7, 1'b0, 8'h27);
        wr(3'h1, 1'b0, 8'h3c);
        wr(3'h0, 1'b1, 8'h31);
        wait_idle(st);
        check(st, 8'h60);
        check(i_display_mem_model.mem[15'h0227], 8'h3c);
        wr(3'h7, 1'b0, 8'h27);
        wr(3'h0, 1'b1, 8'h30);
        wait_idle(st);
        check(st, 8'h20);
        wr(3'h4, 1'b0, 8'h03);
        wr(3'h5, 1'b0, 8'h27);
        wr(3'h0, 1'b1, 8'h35);
        wait_idle(st);
        check(st, 8'h50);
        check(i_display_mem_model.mem[15'h0327], 8'h3c);
    endtask
    task automatic t_abort();
        dly_i <= 8'd80;
        wr(3'h7, 1'b0, 8'h05);
        wr(3'h0, 1'b1, 8'h39);
        wr(3'h2, 1'b0, 8'hee);
        rd(3'h0, 8'h80);
        wr(3'h0, 1'b1, 8'h91);
        dly_i <= 8'd1;
        wait_idle(st);
        check(st, 8'h00);
        rd(3'h2, 8'h58);
    endtask
    task automatic t_mask();
        sync_i <= 1'b1;
        wr(3'h0, 1'b1, 8'h95);
        wait_idle(st);
        check(st, 8'h04);
        sync_i <= 1'b0;
        rd(3'h0, 8'h00);
        sync_i <= 1'b1;
        wr(3'h0, 1'b1, 8'h99);
        wait_idle(st);
        check(st, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    // The ceiling is about sixteen times the expected run so slow memory is not mistaken.
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            $display("Error at %0t: run did not finish", $time);
            summarize();
        end
    end
    initial begin
        rst_b_i = 1'b0; ad_i = 8'h00; as_i = 1'b1; ds_i = 1'b0; rw_i = 1'b1;
        cs_b_i = 1'b1; sync_i = 1'b1; dly_i = 8'd3;
        n_errors = 0; compares = 0; cycles = 0;
        repeat (16) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        wr(3'h0, 1'b1, 8'h91);
        rd(3'h0, 8'h00);
        t_regs();
        t_byte_read();
        t_row_end();
        t_abort();
        t_mask();
        summarize();
    end
endmodule
